// *** hdl/uart_irq_consts.vh ***
// Offsets, fields, reset values and codes for the interrupt identification and queue control
`ifndef UART_IRQ_CONSTS_VH
`define UART_IRQ_CONSTS_VH

// Register indexes, byte address is four times the index
`define IDX_SRC_ENABLE 6'h01
`define IDX_DIV_HIGH 6'h01
`define IDX_IDENT_QUEUE 6'h02
`define IDX_LINE_FORMAT 6'h03
`define IDX_EXT_FEATURE 6'h04
`define IDX_IRQ_STATUS 6'h05
`define IDX_IRQ_MASK 6'h06

// Reset values
`define RST_IDENT 8'h01
`define RST_QUEUE 8'h00
`define RST_LINE_FORMAT 8'h1D
`define RST_EXT_FEATURE 8'h00
`define RST_DIV_HIGH 8'h00
`define RST_SRC_ENABLE 8'h00
`define RST_IRQ_MASK 8'h00
`define RST_IRQ_STATUS 8'h00

// Field positions
`define QC_FIFO_EN 0
`define QC_RX_FLUSH 1
`define QC_TX_FLUSH 2
`define QC_TX_TRIG_LSB 4
`define QC_TX_TRIG_MSB 5
`define QC_RX_TRIG_LSB 6
`define QC_RX_TRIG_MSB 7
`define LFC_DIV_OPEN 7
`define EFC_ENHANCED 4

// Trigger levels in characters or spaces
`define RX_TRIG_00 7'h08
`define RX_TRIG_01 7'h10
`define RX_TRIG_10 7'h38
`define RX_TRIG_11 7'h3C
`define TX_TRIG_00 7'h08
`define TX_TRIG_01 7'h10
`define TX_TRIG_10 7'h20
`define TX_TRIG_11 7'h38
`define TRIG_SINGLE 7'h01
`define FIFO_DEPTH 7'h40

// Source bit positions, index 0 is the top priority
`define SRC_LINE_ERR 0
`define SRC_RX_TIMEOUT 1
`define SRC_RX_DATA 2
`define SRC_TX_READY 3
`define SRC_MODEM 4
`define SRC_PIN_CHANGE 5
`define SRC_XOFF 6
`define SRC_FLOW_INACTIVE 7
`define SRC_COUNT 8

// Identification codes, bits five to zero
`define ID_NONE 6'h01
`define ID_LINE_ERR 6'h06
`define ID_RX_TIMEOUT 6'h0C
`define ID_RX_DATA 6'h04
`define ID_TX_READY 6'h02
`define ID_MODEM 6'h00
`define ID_PIN_CHANGE 6'h30
`define ID_XOFF 6'h10
`define ID_FLOW_INACTIVE 6'h20

`endif

// *** hdl/irq_priority_encoder.v ***
// Priority encoder from pending sources to the identification code
`timescale 1ns/10ps
`include "uart_irq_consts.vh"

module irq_priority_encoder (
   input wire [7:0] pending,
   output reg [5:0] code
);

   // Lowest priority first so the highest pending source overwrites
   always @* begin
      code = `ID_NONE;
      if (pending[`SRC_FLOW_INACTIVE]) begin
         code = `ID_FLOW_INACTIVE;
      end
      if (pending[`SRC_XOFF]) begin
         code = `ID_XOFF;
      end
      if (pending[`SRC_PIN_CHANGE]) begin
         code = `ID_PIN_CHANGE;
      end
      if (pending[`SRC_MODEM]) begin
         code = `ID_MODEM;
      end
      if (pending[`SRC_TX_READY]) begin
         code = `ID_TX_READY;
      end
      if (pending[`SRC_RX_DATA]) begin
         code = `ID_RX_DATA;
      end
      if (pending[`SRC_RX_TIMEOUT]) begin
         code = `ID_RX_TIMEOUT;
      end
      if (pending[`SRC_LINE_ERR]) begin
         code = `ID_LINE_ERR;
      end
   end

endmodule // irq_priority_encoder

// *** hdl/uart_irq_ident_fifo_ctrl.v ***
// UART interrupt identification and queue control with an APB register slave
//
// How it works
// - Index 02H reads identification and writes queue control while divisor access is closed.
// - Identification bit 0 is high with nothing pending, low otherwise.
// - Codes: line error 000110, timeout 001100, rx data 000100, tx 000010, modem 000000.
// - Input pin change reports code 110000 at priority five.
// - Xoff or special character reports code 010000 at priority six.
// - Flow signal going inactive reports code 100000 at priority seven.
// - Queue control bits 7:6 pick receive trigger 8, 16, 56 or 60.
// - Queue control bits 5:4 pick transmit trigger 8, 16, 32 or 56.
// - Transmit trigger bits are ignored unless the enhanced enable is set.
// - Bit 2 written one flushes transmit queue for one cycle, shifter untouched.
// - Bit 1 written one flushes receive queue for one cycle, shifter untouched.
// - Bit 0 one enables both 64-entry queues.
// - Bit 0 zero disables queues, each path holds one character.
// - With queues disabled the other queue control bits are not programmable.
// - With queues disabled the trigger level is one character.
// - Divisor access bit set opens divisor registers and hides index 02H.
// - Enhanced enable gates identification bits 5:4 and the transmit trigger field.
// - Transmit ready when holding empties, or free space exceeds trigger in queue mode.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "uart_irq_consts.vh"

module uart_irq_ident_fifo_ctrl (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire line_err_event,
   input wire rx_timeout_event,
   input wire modem_event,
   input wire pin_change_event,
   input wire xoff_event,
   input wire flow_inactive_event,
   input wire [6:0] rx_fifo_level,
   input wire [6:0] tx_fifo_free,
   input wire thr_empty,
   output wire fifo_enable,
   output wire [6:0] fifo_depth,
   output wire [6:0] rx_trigger_level,
   output wire [6:0] tx_trigger_level,
   output wire tx_fifo_flush,
   output wire rx_fifo_flush,
   output wire [7:0] baud_divisor_high,
   output wire [7:0] line_format_control,
   output wire irq
);

   // Register state
   reg fifo_en_r;
   reg [1:0] rx_trig_sel_r;
   reg [1:0] tx_trig_sel_r;
   reg tx_flush_r;
   reg rx_flush_r;
   reg [7:0] div_high_r;
   reg [7:0] line_format_r;
   reg [7:0] ext_feature_r;
   reg [7:0] src_enable_r;
   reg [7:0] irq_mask_r;
   reg [7:0] irq_status_r;
   reg [7:0] cond_prev_r;
   reg [31:0] prdata_r;
   reg [31:0] prdata_nxt;
   reg [6:0] rx_trig_table;
   reg [6:0] tx_trig_table;
   // Next queue settings and the flops behind the queue control outputs
   reg fifo_en_nxt;
   reg [1:0] rx_trig_sel_nxt;
   reg [1:0] tx_trig_sel_nxt;
   reg [6:0] rx_trigger_r;
   reg [6:0] tx_trigger_r;
   reg [6:0] tx_table_r;
   reg [6:0] fifo_depth_r;
   reg addr_ok;

   // Decode, status and source nets
   wire [5:0] idx;
   wire div_open;
   wire enhanced;
   wire setup_phase;
   wire access_phase;
   wire wr_access;
   wire wr_queue;
   wire wr_status;
   wire [7:0] cond;
   wire [7:0] rise;
   wire [7:0] pending;
   wire [5:0] ident_code;
   wire [7:0] ident_value;
   wire rx_data_cond;
   wire tx_ready_cond;

   assign idx = paddr[7:2];
   assign div_open = line_format_r[`LFC_DIV_OPEN];
   assign enhanced = ext_feature_r[`EFC_ENHANCED];
   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;

   // Address decode, index 02H follows the divisor access bit
   // Misaligned byte addresses are refused so software cannot alias a register
   always @* begin
      addr_ok = 1'b0;
      if (paddr[1:0] == 2'b00) begin
         case (idx)
            `IDX_SRC_ENABLE: begin
               addr_ok = 1'b1;
            end
            `IDX_IDENT_QUEUE: begin
               addr_ok = ~div_open;
            end
            `IDX_LINE_FORMAT, `IDX_EXT_FEATURE, `IDX_IRQ_STATUS, `IDX_IRQ_MASK: begin
               addr_ok = 1'b1;
            end
            default: begin
               addr_ok = 1'b0;
            end
         endcase
      end
   end

   // Zero wait states; read data is captured in the setup cycle
   // The error answer comes in the same access cycle, so no wait state is needed
   assign pready = 1'b1;
   assign pslverr = access_phase & ~addr_ok;
   assign prdata = prdata_r;

   // Write strobes, only for mapped addresses so a refused access changes nothing
   assign wr_access = access_phase & pwrite & addr_ok;
   assign wr_queue = wr_access & (idx == `IDX_IDENT_QUEUE);
   assign wr_status = wr_access & (idx == `IDX_IRQ_STATUS);

   // Next queue settings; a write with bit 0 clear only turns the queues off
   // Decoding the next state lets the trigger outputs come straight from flops
   always @* begin
      fifo_en_nxt = fifo_en_r;
      rx_trig_sel_nxt = rx_trig_sel_r;
      tx_trig_sel_nxt = tx_trig_sel_r;
      if (wr_queue) begin
         fifo_en_nxt = pwdata[`QC_FIFO_EN];
         // Other fields move only when the same write keeps the queues on
         if (pwdata[`QC_FIFO_EN]) begin
            rx_trig_sel_nxt = pwdata[`QC_RX_TRIG_MSB:`QC_RX_TRIG_LSB];
            if (enhanced) begin
               tx_trig_sel_nxt = pwdata[`QC_TX_TRIG_MSB:`QC_TX_TRIG_LSB];
            end
         end
      end
   end

   // Trigger tables, looked up from the next settings
   always @* begin
      case (rx_trig_sel_nxt)
         2'b00: rx_trig_table = `RX_TRIG_00;
         2'b01: rx_trig_table = `RX_TRIG_01;
         2'b10: rx_trig_table = `RX_TRIG_10;
         default: rx_trig_table = `RX_TRIG_11;
      endcase
      case (tx_trig_sel_nxt)
         2'b00: tx_trig_table = `TX_TRIG_00;
         2'b01: tx_trig_table = `TX_TRIG_01;
         2'b10: tx_trig_table = `TX_TRIG_10;
         default: tx_trig_table = `TX_TRIG_11;
      endcase
   end

   // Outputs straight from flops, so no level glitches at the pins
   assign rx_trigger_level = rx_trigger_r;
   assign tx_trigger_level = tx_trigger_r;
   assign fifo_depth = fifo_depth_r;
   assign fifo_enable = fifo_en_r;
   assign tx_fifo_flush = tx_flush_r;
   assign rx_fifo_flush = rx_flush_r;
   assign baud_divisor_high = div_high_r;
   assign line_format_control = line_format_r;

   // Queue control state and its registered outputs
   // The effective triggers are stored too, costing flops but no output glitches
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_en_r <= 1'b0;
         rx_trig_sel_r <= 2'b00;
         tx_trig_sel_r <= 2'b00;
         tx_flush_r <= 1'b0;
         rx_flush_r <= 1'b0;
         rx_trigger_r <= `TRIG_SINGLE;
         tx_trigger_r <= `TRIG_SINGLE;
         tx_table_r <= `TX_TRIG_00;
         fifo_depth_r <= `TRIG_SINGLE;
      end else begin
         fifo_en_r <= fifo_en_nxt;
         rx_trig_sel_r <= rx_trig_sel_nxt;
         tx_trig_sel_r <= tx_trig_sel_nxt;
         // Single character mode collapses both triggers to one
         rx_trigger_r <= fifo_en_nxt ? rx_trig_table : `TRIG_SINGLE;
         tx_trigger_r <= fifo_en_nxt ? tx_trig_table : `TRIG_SINGLE;
         // Programmed transmit level, kept in single mode too for the ready test
         tx_table_r <= tx_trig_table;
         fifo_depth_r <= fifo_en_nxt ? `FIFO_DEPTH : `TRIG_SINGLE;
         // Flush bits clear themselves: high for one cycle only
         tx_flush_r <= 1'b0;
         rx_flush_r <= 1'b0;
         if (wr_queue && pwdata[`QC_FIFO_EN]) begin
            tx_flush_r <= pwdata[`QC_TX_FLUSH];
            rx_flush_r <= pwdata[`QC_RX_FLUSH];
         end
      end
   end

   // Plain read and write registers
   // Divisor high shares index 1 with the source enables, chosen by the access bit
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_high_r <= `RST_DIV_HIGH;
         line_format_r <= `RST_LINE_FORMAT;
         ext_feature_r <= `RST_EXT_FEATURE;
         src_enable_r <= `RST_SRC_ENABLE;
         irq_mask_r <= `RST_IRQ_MASK;
      end else if (wr_access) begin
         case (idx)
            `IDX_SRC_ENABLE: begin
               if (div_open) begin
                  div_high_r <= pwdata[7:0];
               end else begin
                  src_enable_r <= pwdata[7:0];
               end
            end
            `IDX_LINE_FORMAT: begin
               line_format_r <= pwdata[7:0];
            end
            `IDX_EXT_FEATURE: begin
               ext_feature_r <= pwdata[7:0];
            end
            `IDX_IRQ_MASK: begin
               irq_mask_r <= pwdata[7:0];
            end
            default: begin
               div_high_r <= div_high_r;
            end
         endcase
      end
   end

   // Source conditions; data and transmit ready are levels, the rest pulses
   // Receive data compares against the effective trigger, one in single mode
   assign rx_data_cond = (rx_fifo_level >= rx_trigger_level);
   assign tx_ready_cond = fifo_en_r ? (tx_fifo_free > tx_table_r) : thr_empty;
   assign cond = {flow_inactive_event, xoff_event, pin_change_event, modem_event,
                  tx_ready_cond, rx_data_cond, rx_timeout_event, line_err_event};
   assign rise = cond & ~cond_prev_r;

   // Edge history so a level that stays high sets its flag only once
   // Cleared by reset, so a level already high afterwards raises its flag once
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cond_prev_r <= 8'h00;
      end else begin
         cond_prev_r <= cond;
      end
   end

   // Sticky flags, one per source; a new event beats a clear in the same cycle
   // One process per bit keeps each flag's set and clear side by side
   genvar g;
   generate
      for (g = 0; g < `SRC_COUNT; g = g + 1) begin : g_flag
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               irq_status_r[g] <= 1'b0;
            end else if (rise[g]) begin
               irq_status_r[g] <= 1'b1;
            end else if (wr_status && pwdata[g]) begin
               irq_status_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Extended sources only reach the identification while the enhanced enable is set
   assign pending = irq_status_r & src_enable_r &
                    {{3{enhanced}}, 5'h1F};

   // Priority encoder picks the top pending source
   irq_priority_encoder u_enc (
      .pending(pending),
      .code(ident_code)
   );

   // Top bits mirror the queue enable
   assign ident_value = {fifo_en_r, fifo_en_r, ident_code};

   // Pin uses the mask register; the identification uses the source enables
   assign irq = |(irq_status_r & irq_mask_r);

   // Read mux
   // Unmapped or hidden addresses read as zero alongside the error response
   always @* begin
      prdata_nxt = 32'h00000000;
      case (idx)
         `IDX_SRC_ENABLE: begin
            prdata_nxt[7:0] = div_open ? div_high_r : src_enable_r;
         end
         `IDX_IDENT_QUEUE: begin
            prdata_nxt[7:0] = div_open ? 8'h00 : ident_value;
         end
         `IDX_LINE_FORMAT: begin
            prdata_nxt[7:0] = line_format_r;
         end
         `IDX_EXT_FEATURE: begin
            prdata_nxt[7:0] = ext_feature_r;
         end
         `IDX_IRQ_STATUS: begin
            prdata_nxt[7:0] = irq_status_r;
         end
         `IDX_IRQ_MASK: begin
            prdata_nxt[7:0] = irq_mask_r;
         end
         default: begin
            prdata_nxt = 32'h00000000;
         end
      endcase
      if (!addr_ok) begin
         prdata_nxt = 32'h00000000;
      end
   end

   // Captured in setup so the answer comes from a flop with no wait state
   // Limitation: a flag set during the access cycle shows on the next read only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else if (setup_phase && !pwrite) begin
         prdata_r <= prdata_nxt;
      end
   end

endmodule // uart_irq_ident_fifo_ctrl

// *** bench/uart_irq_monitor.sv ***
// Port checks for the identification and queue control block
`timescale 1ns/10ps
module uart_irq_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire logic fifo_enable,
   input wire logic [6:0] fifo_depth,
   input wire logic [6:0] rx_trigger_level,
   input wire logic [6:0] tx_trigger_level,
   input wire logic tx_fifo_flush,
   input wire logic rx_fifo_flush,
   input wire logic [7:0] line_format_control
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Queue control write that the block accepts
   wire queue_wr = psel && penable && pwrite && paddr == 8'h08 && !pslverr;
   // Own copy of the receive table, so a shared slip cannot hide
   function automatic logic [6:0] rx_tab(input logic [31:0] d);
      return d[7:6] == 2'h0 ? 7'h08 : d[7:6] == 2'h1 ? 7'h10 : d[7:6] == 2'h2 ? 7'h38 : 7'h3C;
   endfunction
   depth_mode_a: assert property (fifo_depth == (fifo_enable ? 7'h40 : 7'h01))
      else $error("depth wrong");
   single_trig_a: assert property (!fifo_enable |-> rx_trigger_level == 7'h01
      && tx_trigger_level == 7'h01) else $error("single trigger wrong");
   rx_trig_a: assert property (queue_wr && pwdata[0] |=> rx_trigger_level == rx_tab($past(pwdata)))
      else $error("rx trigger wrong");
   fifo_off_a: assert property (queue_wr && !pwdata[0] |=> !fifo_enable)
      else $error("queue still on");
   tx_flush_a: assert property (queue_wr && pwdata[0] && pwdata[2] |=> tx_fifo_flush ##1 !tx_fifo_flush)
      else $error("tx flush pulse wrong");
   rx_flush_a: assert property (queue_wr && pwdata[0] && pwdata[1] |=> rx_fifo_flush ##1 !rx_fifo_flush)
      else $error("rx flush pulse wrong");
   flush_cause_a: assert property (tx_fifo_flush || rx_fifo_flush |-> $past(queue_wr) && $past(pwdata[0]))
      else $error("flush without cause");
   hidden_ident_a: assert property (psel && penable && paddr == 8'h08 && line_format_control[7] |-> pslverr)
      else $error("index 2 not hidden");
   cover property (tx_fifo_flush && rx_fifo_flush);
   cover property (queue_wr && !pwdata[0]);
   cover property (psel && penable && line_format_control[7]);
endmodule // uart_irq_monitor

// *** bench/apb_host_model.sv ***
// Register bus master standing in for the host controller
`timescale 1ns/10ps
module apb_host_model (
   input wire logic pclk,
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output logic [7:0] paddr = 8'h00,
   output logic [31:0] pwdata = 32'h0,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // One transfer; the leading edge keeps release and next setup apart
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // apb_host_model

// *** bench/testbench.sv ***
// Self-checking bench for the identification and queue control block
`timescale 1ns/10ps
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic thr_empty = 1'b0;
   logic [5:0] ev = 6'h00;
   logic [6:0] rx_fifo_level = 7'h00;
   logic [6:0] tx_fifo_free = 7'h00;
   wire psel, penable, pwrite, pready, pslverr, irq, fifo_enable, tx_fifo_flush, rx_fifo_flush;
   wire [7:0] paddr, baud_divisor_high, line_format_control;
   wire [31:0] pwdata, prdata;
   wire [6:0] fifo_depth, rx_trigger_level, tx_trigger_level;
   int mismatches = 0;
   int samples_checked = 0;
   logic [31:0] rdv;
   logic err;
   uart_irq_ident_fifo_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .line_err_event(ev[0]), .rx_timeout_event(ev[1]),
      .modem_event(ev[2]), .pin_change_event(ev[3]), .xoff_event(ev[4]),
      .flow_inactive_event(ev[5]), .rx_fifo_level, .tx_fifo_free, .thr_empty, .fifo_enable,
      .fifo_depth, .rx_trigger_level, .tx_trigger_level, .tx_fifo_flush, .rx_fifo_flush,
      .baud_divisor_high, .line_format_control, .irq);
   apb_host_model i_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr);
   initial forever #4 pclk = ~pclk;
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d, rdv, err);
   endtask
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] exp);
      i_host.xfer(1'b0, a, 32'h0, rdv, err);
      chk(n, rdv, exp);
   endtask
   task automatic t_reset;
      chk("depth", fifo_depth, 32'h01);
      chk("fifo on", fifo_enable, 32'h0);
      chk("line fmt", line_format_control, 32'h1D);
      chk("div rst", baud_divisor_high, 32'h0);
      chk("ready", pready, 32'h1);
      chk("irq rst", irq, 32'h0);
      chk("rx trig", rx_trigger_level, 32'h01);
      rd("ident", 8'h08, 32'h01);
      rd("unmapped", 8'h1C, 32'h0);
      chk("unmapped err", err, 32'h1);
   endtask
   task automatic t_queue;
      logic [6:0] rx_t [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
      logic [6:0] tx_t [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
      wr(8'h10, 32'h10);
      for (int i = 0; i < 4; i++) begin
         wr(8'h08, {24'h0, i[1:0], i[1:0], 4'h1});
         #1;
         chk("rx trig", rx_trigger_level, rx_t[i]);
         chk("tx trig", tx_trigger_level, tx_t[i]);
         chk("depth", fifo_depth, 32'h40);
         chk("fifo on", fifo_enable, 32'h1);
      end
      rd("ident mirror", 8'h08, 32'hC1);
      wr(8'h08, 32'h00);
      wr(8'h08, 32'hF6);
      #1;
      chk("off trig", tx_trigger_level, 32'h01);
      chk("off flush", {tx_fifo_flush, rx_fifo_flush}, 32'h0);
      wr(8'h08, 32'h01);
      wr(8'h10, 32'h00);
      wr(8'h08, 32'h31);
      #1;
      chk("tx gated", tx_trigger_level, 32'h08);
   endtask
   task automatic t_flush;
      wr(8'h08, 32'h07);
      #1;
      chk("flush", {tx_fifo_flush, rx_fifo_flush}, 32'h3);
      @(posedge pclk) #1;
      chk("flush end", {tx_fifo_flush, rx_fifo_flush}, 32'h0);
   endtask
   task automatic t_div;
      wr(8'h0C, 32'h9D);
      rd("hidden", 8'h08, 32'h0);
      chk("hidden err", err, 32'h1);
      wr(8'h04, 32'h5A);
      #1;
      chk("div high", baud_divisor_high, 32'h5A);
      wr(8'h0C, 32'h1D);
      rd("ident back", 8'h08, 32'hC1);
   endtask
   task automatic t_irq;
      logic [5:0] code [8] = '{6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h30, 6'h10, 6'h20};
      wr(8'h10, 32'h10);
      wr(8'h08, 32'h00);
      wr(8'h04, 32'hFF);
      wr(8'h18, 32'hFF);
      ev <= 6'h3F;
      thr_empty <= 1'b1;
      rx_fifo_level <= 7'h01;
      @(posedge pclk);
      ev <= 6'h00;
      rd("status", 8'h14, 32'hFF);
      chk("irq", irq, 32'h1);
      wr(8'h18, 32'h00);
      #1;
      chk("masked irq", irq, 32'h0);
      wr(8'h18, 32'hFF);
      // Clearing the top source must reveal the next one down
      for (int i = 0; i < 8; i++) begin
         rd("ident", 8'h08, {26'h0, code[i]});
         wr(8'h14, 32'h1 << i);
      end
      rd("ident idle", 8'h08, 32'h01);
      wr(8'h08, 32'h01);
      tx_fifo_free <= 7'h08;
      rd("at trigger", 8'h08, 32'hC1);
      tx_fifo_free <= 7'h09;
      rd("above trigger", 8'h08, 32'hC2);
      // Pin change stays hidden from the identification until the enhanced enable is set
      wr(8'h10, 32'h00);
      wr(8'h14, 32'hFF);
      ev <= 6'h08;
      @(posedge pclk);
      ev <= 6'h00;
      rd("pin hidden", 8'h08, 32'hC1);
      wr(8'h10, 32'h10);
      rd("pin shown", 8'h08, 32'hF0);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_queue;
      t_flush;
      t_div;
      t_irq;
      results;
   end
   // Watchdog well beyond the roughly 160 cycles the run needs
   initial begin
      repeat (5000) @(posedge pclk);
      mismatches++;
      results;
   end
endmodule // testbench
bind uart_irq_ident_fifo_ctrl uart_irq_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pslverr, .fifo_enable, .fifo_depth, .rx_trigger_level, .tx_trigger_level,
   .tx_fifo_flush, .rx_fifo_flush, .line_format_control);
